// *** hdl/dhi_params.svh ***
`ifndef DHI_PARAMS_SVH
`define DHI_PARAMS_SVH
// register indices selected by the two address pins
`define DHI_ADDR_MSG 2'h0
`define DHI_ADDR_CTRL 2'h1
`define DHI_ADDR_PCM 2'h2
`define DHI_ADDR_CMP 2'h3
// control register bit positions
`define DHI_BIT_CMP_RST 6
`define DHI_BIT_PCM_RST 5
`define DHI_BIT_PCM_AF 4
`define DHI_BIT_CMP_AF 3
`define DHI_BIT_IN_BUSY 2
`define DHI_BIT_OUT_RDY 1
// reset values
`define DHI_SER_ADDR_RST 7'h00
`define DHI_ADDR_CHECK_RST 1'b1
`define DHI_CHAN_RST_RST 1'b0
// serial framing: bit index of the last and second-to-last bit
`define DHI_BIT_LAST 3'h7
`define DHI_BIT_PENULT 3'h6
`endif

// *** hdl/dhi_pkg.sv ***
package dhi_pkg;
    // parallel access state, one-hot
    typedef enum logic [2:0] {
        PAR_IDLE  = 3'b001,
        PAR_READ  = 3'b010,
        PAR_WRITE = 3'b100
    } dhi_par_st_t;
    // one byte of host data
    typedef logic [7:0] dhi_byte_t;
endpackage

// *** hdl/dhi_serial_link.sv ***
`include "dhi_params.svh"
module dhi_serial_link (
    input  wire logic             serial_control_clock, // host serial clock
    input  wire logic             cs_n,       // frame select, low in frame
    input  wire logic             serial_in,  // serial data from host
    input  wire logic             link_rst,   // core reset, high
    input  wire logic [6:0]       dev_addr,   // own serial address
    input  wire logic             addr_check, // address compare enable
    input  wire dhi_pkg::dhi_byte_t out_byte, // outbound byte, held
    input  wire logic             out_ready,  // outbound byte waiting
    output logic                  serial_out, // serial data to host
    output dhi_pkg::dhi_byte_t    rx_byte,    // last received byte
    output logic                  rx_tgl,     // flips per received byte
    output logic                  ld_tgl,     // flips per loaded byte
    output logic                  rel_tgl     // flips at penultimate bit
);
    logic               frame_clr;        // frame end or core reset
    dhi_pkg::dhi_byte_t sh_r, sh_nxt;     // input shift register
    logic [2:0]         bit_r, bit_nxt;   // bit index in byte
    logic               hdr_r, hdr_nxt;   // address byte done
    logic               rd_r, rd_nxt;     // frame is a read
    logic               hit_r, hit_nxt;   // address matched
    logic               endh_r, endh_nxt; // address byte just ended
    logic               endp_r, endp_nxt; // payload byte just ended
    logic               rel_nxt;          // next release toggle
    dhi_pkg::dhi_byte_t tx_r, tx_nxt;     // output shift register
    logic               rdy_m, rdy_s;     // ready synchroniser
    logic               load;             // load next outbound byte

    // the frame state dies with the select line
    assign frame_clr = cs_n | link_rst;

    // rising edge: sample input, count bits, decode the header
    always_comb begin
        sh_nxt   = {sh_r[6:0], serial_in};
        bit_nxt  = bit_r + 3'h1;
        hdr_nxt  = hdr_r | (bit_r == `DHI_BIT_LAST);
        rd_nxt   = rd_r;
        hit_nxt  = hit_r;
        endh_nxt = (bit_r == `DHI_BIT_LAST) & ~hdr_r;
        endp_nxt = (bit_r == `DHI_BIT_LAST) & hdr_r;
        rel_nxt  = rel_tgl;
        // eighth header bit is the direction bit
        if (~hdr_r && bit_r == `DHI_BIT_LAST) begin
            rd_nxt  = serial_in;
            hit_nxt = ~addr_check | (sh_r[6:0] == dev_addr);
        end
        // release point is the second-to-last bit of a read byte
        if (hdr_r && rd_r && hit_r && bit_r == `DHI_BIT_PENULT) begin
            rel_nxt = ~rel_tgl;
        end
    end

    // frame registers, cleared whenever select is high
    always_ff @(posedge serial_control_clock or posedge frame_clr) begin
        if (frame_clr) begin
            sh_r   <= 8'h00;
            bit_r  <= 3'h0;
            hdr_r  <= 1'b0;
            rd_r   <= 1'b0;
            hit_r  <= 1'b0;
            endh_r <= 1'b0;
            endp_r <= 1'b0;
        end else begin
            sh_r   <= sh_nxt;
            bit_r  <= bit_nxt;
            hdr_r  <= hdr_nxt;
            rd_r   <= rd_nxt;
            hit_r  <= hit_nxt;
            endh_r <= endh_nxt;
            endp_r <= endp_nxt;
        end
    end

    // release toggle survives frame ends
    always_ff @(posedge serial_control_clock or posedge link_rst) begin
        if (link_rst) rel_tgl <= 1'b0;
        else rel_tgl <= rel_nxt;
    end

    // falling edge: load or shift outbound data
    assign load = rd_r & hit_r & (endh_r | endp_r);
    always_comb begin
        tx_nxt = {tx_r[6:0], 1'b0};
        if (load) begin
            tx_nxt = rdy_s ? out_byte : 8'h00;
        end
    end

    // output shifter changes on falling edges, cleared when select rises or on core reset
    always_ff @(negedge serial_control_clock or posedge frame_clr) begin
        if (frame_clr) tx_r <= 8'h00;
        else tx_r <= tx_nxt;
    end
    assign serial_out = tx_r[7];

    // hand-off registers, kept across frames
    always_ff @(negedge serial_control_clock or posedge link_rst) begin
        if (link_rst) begin
            rdy_m   <= 1'b0;
            rdy_s   <= 1'b0;
            rx_byte <= 8'h00;
            rx_tgl  <= 1'b0;
            ld_tgl  <= 1'b0;
        end else begin
            rdy_m <= out_ready;
            rdy_s <= rdy_m;
            // byte passes on the falling edge after its eighth bit
            if (endp_r && !rd_r && hit_r && !frame_clr) begin
                rx_byte <= sh_r;
                rx_tgl  <= ~rx_tgl;
            end
            if (load && rdy_s) ld_tgl <= ~ld_tgl;
        end
    end
endmodule

// *** hdl/dhi_host_port.sv ***
`include "dhi_params.svh"
module dhi_host_port (
    input  wire logic             clk,           // core clock
    input  wire logic             reset,         // sync reset, high
    input  wire logic             spi_mode,      // strap: serial mode
    input  wire logic             cs_n,          // chip select pin
    input  wire logic             data_strobe_n, // data strobe pin
    input  wire logic             rw,            // high read, low write
    input  wire logic [1:0]       addr,          // register select
    input  wire dhi_pkg::dhi_byte_t data_in,     // data bus input
    output dhi_pkg::dhi_byte_t    data_out,      // data bus output
    output logic                  data_oe,       // data bus enable
    input  wire logic             serial_control_clock, // serial clock
    input  wire logic             serial_in,     // serial data in
    output logic                  serial_out,    // serial data out
    output logic                  host_attention_n_out, // pin level
    output logic                  host_attention_n_oe,  // pulls low
    input  wire logic             dsp_msg_take,  // DSP read inbound
    input  wire logic             dsp_msg_put,   // DSP write outbound
    input  wire dhi_pkg::dhi_byte_t dsp_msg_byte, // outbound byte
    output dhi_pkg::dhi_byte_t    msg_to_dsp,    // inbound byte
    output logic                  inbound_message_busy,   // flag
    output logic                  outbound_message_ready, // flag
    input  wire logic             pcm_buffer_almost_full, // level
    input  wire logic             compressed_buffer_almost_full,
    output logic                  pcm_push,      // PCM byte strobe
    output dhi_pkg::dhi_byte_t    pcm_byte,      // PCM byte
    output logic                  cmp_push,      // compressed strobe
    output dhi_pkg::dhi_byte_t    cmp_byte,      // compressed byte
    output logic                  pcm_channel_reset,        // hold
    output logic                  compressed_channel_reset, // hold
    input  wire logic             cfg_addr_load, // load address cfg
    input  wire logic [6:0]       cfg_addr,      // new serial address
    input  wire logic             cfg_addr_check // compare enable
);
    // pin synchroniser, 14 bits wide
    localparam int PW = 14;
    logic [PW-1:0]       pin_raw;   // raw pins
    logic [PW-1:0]       pin_m;     // first stage
    logic [PW-1:0]       pin_s;     // second stage
    logic                cs_s;      // synced select
    logic                ds_s;      // synced strobe
    logic                rw_s;      // synced direction
    logic                mode_s;    // synced mode strap
    logic [1:0]          addr_s;    // synced address
    dhi_pkg::dhi_byte_t  data_s;    // synced data
    // toggle crossings from the serial side
    logic [2:0]          tg_raw;    // rx, load, release
    logic [2:0]          tg_m;      // first stage
    logic [2:0]          tg_s;      // second stage
    logic [2:0]          tg_p;      // previous second stage
    logic                rx_ev;     // byte received
    logic                ld_ev;     // outbound byte taken
    logic                rel_ev;    // penultimate bit reached
    dhi_pkg::dhi_byte_t  rx_byte;   // byte from serial side
    // parallel access state
    dhi_pkg::dhi_par_st_t st_r, st_nxt;
    logic [1:0]          a_r, a_nxt;  // address of access
    dhi_pkg::dhi_byte_t  d_r, d_nxt;  // captured write data
    logic                act;         // access active
    logic                wr_done;     // write ends this cycle
    logic                rd_done;     // read ends this cycle
    logic                in_set;      // inbound flag set cause
    logic                out_clr;     // outbound flag clear cause
    // register file and output state
    dhi_pkg::dhi_byte_t  msg_in_r, msg_in_nxt;    // inbound byte
    dhi_pkg::dhi_byte_t  msg_out_r, msg_out_nxt;  // outbound byte
    logic                busy_r, busy_nxt;        // inbound flag
    logic                rdy_r, rdy_nxt;          // outbound flag
    logic                pcm_rst_r, pcm_rst_nxt;  // PCM reset hold
    logic                cmp_rst_r, cmp_rst_nxt;  // compressed hold
    logic                pcm_push_r, pcm_push_nxt;
    dhi_pkg::dhi_byte_t  pcm_byte_r, pcm_byte_nxt;
    logic                cmp_push_r, cmp_push_nxt;
    dhi_pkg::dhi_byte_t  cmp_byte_r, cmp_byte_nxt;
    dhi_pkg::dhi_byte_t  dout_r, dout_nxt;        // read data
    logic                doe_r, doe_nxt;          // bus enable
    logic                attn_r, attn_nxt;        // attention pull
    logic [6:0]          sadr_r, sadr_nxt;        // serial address
    logic                schk_r, schk_nxt;        // compare enable
    logic                link_rst_r;              // serial side reset

    // read-back value of a register; write-only ones read zero
    function automatic dhi_pkg::dhi_byte_t rd_value(
        input logic [1:0] a
    );
        dhi_pkg::dhi_byte_t v;
        v = 8'h00;
        if (a == `DHI_ADDR_MSG) begin
            v = msg_out_r;
        end else if (a == `DHI_ADDR_CTRL) begin
            v[`DHI_BIT_PCM_AF]  = pcm_buffer_almost_full;
            v[`DHI_BIT_CMP_AF]  = compressed_buffer_almost_full;
            v[`DHI_BIT_IN_BUSY] = busy_r;
            v[`DHI_BIT_OUT_RDY] = rdy_r;
        end
        return v;
    endfunction

    // bus pins and mode strap pass two flops; the serial link takes its pins raw
    assign pin_raw = {spi_mode, cs_n, data_strobe_n, rw, addr, data_in};
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_m <= 14'h3FFF;
            pin_s <= 14'h3FFF;
        end else begin
            pin_m <= pin_raw;
            pin_s <= pin_m;
        end
    end
    assign mode_s = pin_s[13];
    assign cs_s   = pin_s[12];
    assign ds_s   = pin_s[11];
    assign rw_s   = pin_s[10];
    assign addr_s = pin_s[9:8];
    assign data_s = pin_s[7:0];

    // toggle synchronisers for serial side events
    always_ff @(posedge clk) begin
        if (reset) begin
            tg_m <= 3'h0;
            tg_s <= 3'h0;
            tg_p <= 3'h0;
        end else begin
            tg_m <= tg_raw;
            tg_s <= tg_m;
            tg_p <= tg_s;
        end
    end
    assign rx_ev  = tg_s[0] ^ tg_p[0];
    assign ld_ev  = tg_s[1] ^ tg_p[1];
    assign rel_ev = tg_s[2] ^ tg_p[2];

    // serial side runs on the host clock
    dhi_serial_link u_link (
        .serial_control_clock (serial_control_clock),
        .cs_n                 (cs_n),
        .serial_in            (serial_in),
        .link_rst             (link_rst_r),
        .dev_addr             (sadr_r),
        .addr_check           (schk_r),
        .out_byte             (msg_out_r),
        .out_ready            (rdy_r),
        .serial_out           (serial_out),
        .rx_byte              (rx_byte),
        .rx_tgl               (tg_raw[0]),
        .ld_tgl               (tg_raw[1]),
        .rel_tgl              (tg_raw[2])
    );

    // strobe and select combine; nothing happens in serial mode
    assign act     = ~cs_s & ~ds_s & ~mode_s;
    assign wr_done = (st_r == dhi_pkg::PAR_WRITE) & ~act;
    assign rd_done = (st_r == dhi_pkg::PAR_READ) & ~act;

    // parallel access sequencing
    always_comb begin
        st_nxt = st_r;
        a_nxt  = a_r;
        d_nxt  = d_r;
        unique case (st_r)
            dhi_pkg::PAR_IDLE: begin
                if (act) begin
                    st_nxt = rw_s ? dhi_pkg::PAR_READ
                                  : dhi_pkg::PAR_WRITE;
                    a_nxt  = addr_s;
                    d_nxt  = data_s;
                end
            end
            dhi_pkg::PAR_READ: begin
                // first strobe to rise ends the read
                if (!act) st_nxt = dhi_pkg::PAR_IDLE;
            end
            dhi_pkg::PAR_WRITE: begin
                // keep sampling while strobes are low
                if (act) d_nxt = data_s;
                else st_nxt = dhi_pkg::PAR_IDLE;
            end
        endcase
    end

    // parallel state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= dhi_pkg::PAR_IDLE;
            a_r  <= 2'h0;
            d_r  <= 8'h00;
        end else begin
            st_r <= st_nxt;
            a_r  <= a_nxt;
            d_r  <= d_nxt;
        end
    end

    // register file, flags and data paths
    assign in_set  = (wr_done & (a_r == `DHI_ADDR_MSG)) | rx_ev;
    assign out_clr = (rd_done & (a_r == `DHI_ADDR_MSG)) | ld_ev;
    always_comb begin
        msg_in_nxt   = msg_in_r;
        msg_out_nxt  = msg_out_r;
        pcm_rst_nxt  = pcm_rst_r;
        cmp_rst_nxt  = cmp_rst_r;
        pcm_byte_nxt = pcm_byte_r;
        cmp_byte_nxt = cmp_byte_r;
        sadr_nxt     = sadr_r;
        schk_nxt     = schk_r;
        // a completed write lands in its register
        pcm_push_nxt = wr_done & (a_r == `DHI_ADDR_PCM);
        cmp_push_nxt = wr_done & (a_r == `DHI_ADDR_CMP);
        if (pcm_push_nxt) pcm_byte_nxt = d_r;
        if (cmp_push_nxt) cmp_byte_nxt = d_r;
        if (wr_done && a_r == `DHI_ADDR_MSG) msg_in_nxt = d_r;
        if (rx_ev) msg_in_nxt = rx_byte;
        // only the two reset holds are writable in control
        if (wr_done && a_r == `DHI_ADDR_CTRL) begin
            cmp_rst_nxt = d_r[`DHI_BIT_CMP_RST];
            pcm_rst_nxt = d_r[`DHI_BIT_PCM_RST];
        end
        if (dsp_msg_put) msg_out_nxt = dsp_msg_byte;
        // set wins over clear on both flags
        busy_nxt = in_set | (busy_r & ~dsp_msg_take);
        rdy_nxt  = dsp_msg_put | (rdy_r & ~out_clr);
        // bus driven only in a read, with live register value
        doe_nxt  = (st_nxt == dhi_pkg::PAR_READ);
        dout_nxt = rd_value(a_nxt);
        // attention pulled while data waits; serial release waits
        if (rdy_r) attn_nxt = 1'b1;
        else if (rel_ev || !mode_s) attn_nxt = 1'b0;
        else attn_nxt = attn_r;
        if (cfg_addr_load) begin
            sadr_nxt = cfg_addr;
            schk_nxt = cfg_addr_check;
        end
    end

    // register file flops
    always_ff @(posedge clk) begin
        if (reset) begin
            msg_in_r   <= 8'h00;
            msg_out_r  <= 8'h00;
            busy_r     <= 1'b0;
            rdy_r      <= 1'b0;
            pcm_rst_r  <= `DHI_CHAN_RST_RST;
            cmp_rst_r  <= `DHI_CHAN_RST_RST;
            pcm_push_r <= 1'b0;
            pcm_byte_r <= 8'h00;
            cmp_push_r <= 1'b0;
            cmp_byte_r <= 8'h00;
            dout_r     <= 8'h00;
            doe_r      <= 1'b0;
            attn_r     <= 1'b0;
            sadr_r     <= `DHI_SER_ADDR_RST;
            schk_r     <= `DHI_ADDR_CHECK_RST;
            link_rst_r <= 1'b1;
        end else begin
            msg_in_r   <= msg_in_nxt;
            msg_out_r  <= msg_out_nxt;
            busy_r     <= busy_nxt;
            rdy_r      <= rdy_nxt;
            pcm_rst_r  <= pcm_rst_nxt;
            cmp_rst_r  <= cmp_rst_nxt;
            pcm_push_r <= pcm_push_nxt;
            pcm_byte_r <= pcm_byte_nxt;
            cmp_push_r <= cmp_push_nxt;
            cmp_byte_r <= cmp_byte_nxt;
            dout_r     <= dout_nxt;
            doe_r      <= doe_nxt;
            attn_r     <= attn_nxt;
            sadr_r     <= sadr_nxt;
            schk_r     <= schk_nxt;
            link_rst_r <= 1'b0;
        end
    end

    // outputs straight from flops
    assign data_out                 = dout_r;
    assign data_oe                  = doe_r;
    assign host_attention_n_out     = link_rst_r & 1'b0;
    assign host_attention_n_oe      = attn_r;
    assign msg_to_dsp               = msg_in_r;
    assign inbound_message_busy     = busy_r;
    assign outbound_message_ready   = rdy_r;
    assign pcm_push                 = pcm_push_r;
    assign pcm_byte                 = pcm_byte_r;
    assign cmp_push                 = cmp_push_r;
    assign cmp_byte                 = cmp_byte_r;
    assign pcm_channel_reset        = pcm_rst_r;
    assign compressed_channel_reset = cmp_rst_r;

    // checks on the core clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    bus_release_a: assert property (disable iff (1'b0)
        reset |=> !data_oe) else $error("bus driven after reset");
    read_drive_a: assert property (
        !act |=> !data_oe) else $error("bus driven without access");
    strobe_gate_a: assert property (
        (st_r == dhi_pkg::PAR_IDLE) && (cs_s || ds_s)
        |=> st_r == dhi_pkg::PAR_IDLE) else $error("access on one strobe");
    write_latch_a: assert property (
        wr_done && a_r == `DHI_ADDR_MSG |=> msg_to_dsp == $past(d_r))
        else $error("message byte not latched");
    pcm_push_a: assert property (
        wr_done && a_r == `DHI_ADDR_PCM
        |=> pcm_push && !cmp_push && pcm_byte == $past(d_r) ##1 !pcm_push)
        else $error("PCM push wrong");
    cmp_push_a: assert property (
        wr_done && a_r == `DHI_ADDR_CMP
        |=> cmp_push && !pcm_push && cmp_byte == $past(d_r))
        else $error("compressed push wrong");
    cmp_hold_a: assert property (
        wr_done && a_r == `DHI_ADDR_CTRL
        |=> compressed_channel_reset == $past(d_r[6]))
        else $error("compressed hold not written");
    pcm_hold_a: assert property (
        wr_done && a_r == `DHI_ADDR_CTRL
        |=> pcm_channel_reset == $past(d_r[5]))
        else $error("PCM hold not written");
    ctrl_read_a: assert property (
        st_nxt == dhi_pkg::PAR_READ && a_nxt == `DHI_ADDR_CTRL
        |=> data_out[4] == $past(pcm_buffer_almost_full)
            && data_out[3] == $past(compressed_buffer_almost_full)
            && data_out[7:5] == 3'h0 && data_out[0] == 1'b0)
        else $error("control read value wrong");
    busy_flag_a: assert property (
        in_set |=> inbound_message_busy ##1
        (inbound_message_busy || $past(dsp_msg_take)))
        else $error("inbound flag lost");
    ready_flag_a: assert property (
        dsp_msg_put |=> outbound_message_ready)
        else $error("outbound flag not set");
    attn_pull_a: assert property (
        outbound_message_ready |=> host_attention_n_oe)
        else $error("attention not pulled");
    attn_keep_a: assert property (
        host_attention_n_oe && !rdy_r && !rel_ev && mode_s
        |=> host_attention_n_oe) else $error("attention dropped early");
    rx_pass_a: assert property (
        rx_ev |=> inbound_message_busy && msg_to_dsp == $past(rx_byte))
        else $error("serial byte not passed");
endmodule

// *** verification/dhi_host_model.sv ***
module dhi_host_model (
    input  wire logic       clk,  // core clock
    input  wire logic [7:0] q,    // bus data from device
    input  wire logic       oe,   // device drives bus
    input  wire logic       sdo,  // serial data from device
    output logic            cs_n, // chip select
    output logic            ds_n, // data strobe
    output logic            rw,   // high read
    output logic [1:0]      a,    // register select
    output logic [7:0]      d,    // bus data to device
    output logic            sclk, // serial clock, still outside frames
    output logic            sdi   // serial data to device
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle host: nothing selected, serial clock parked low
    initial begin
        {cs_n, ds_n, rw, a, d, sclk, sdi} = 15'h7F00;
    end
    // one parallel access; read data taken while strobes still low
    task par(input logic r, input logic [1:0] ad, input logic [7:0] wd,
             output logic [7:0] rd);
        @(negedge clk);
        rw = r;
        a = ad;
        d = wd;
        @(negedge clk);
        cs_n = 1'h0;
        ds_n = 1'h0;
        repeat (6) @(negedge clk);
        rd = (oe === 1'h1) ? q : 8'hEE;
        cs_n = 1'h1;
        ds_n = 1'h1;
        repeat (4) @(negedge clk);
        d = ~wd; // released bus no longer shows old data
    endtask
    // one byte, msb first: data set while low, sampled at rise
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #32 sclk = 1'h1;
            rx[i] = sdo;
            #32 sclk = 1'h0;
        end
        sdi = ~tx[0];
    endtask
    // header then one payload byte, select low throughout
    task frame(input logic [7:0] h, tx, output logic [7:0] rx);
        logic [7:0] junk; // header time read-back, unused
        #7 cs_n = 1'h0;
        xfer(h, junk);
        xfer(tx, rx);
        #20 cs_n = 1'h1;
    endtask
endmodule

// *** verification/decoder_host_interface_tb.sv ***
module decoder_host_interface_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, reset, spi_mode, take, put, paf, caf, cl, cc; // stimulus
    logic [6:0] ca;                            // serial address setting
    logic       cs_n, ds_n, rw, sclk, sdi, sdo, oe, ao, aoe; // pins
    logic       busy, rdy, pp, cp, prst, crst; // device flags
    logic [1:0] a;                             // register select
    logic [3:0] pn, cn;                        // push counts
    logic [7:0] d, mb, rd, plast, clast;       // bytes
    dhi_pkg::dhi_byte_t q, m2d, pb, cb;        // device bytes
    int         errors, checks;                // verdict counters
    dhi_host_port DUT (.clk(clk), .reset(reset), .spi_mode(spi_mode),
        .cs_n(cs_n), .data_strobe_n(ds_n), .rw(rw), .addr(a),
        .data_in(d), .data_out(q), .data_oe(oe),
        .serial_control_clock(sclk), .serial_in(sdi), .serial_out(sdo),
        .host_attention_n_out(ao), .host_attention_n_oe(aoe),
        .dsp_msg_take(take), .dsp_msg_put(put), .dsp_msg_byte(mb),
        .msg_to_dsp(m2d), .inbound_message_busy(busy),
        .outbound_message_ready(rdy), .pcm_buffer_almost_full(paf),
        .compressed_buffer_almost_full(caf), .pcm_push(pp),
        .pcm_byte(pb), .cmp_push(cp), .cmp_byte(cb),
        .pcm_channel_reset(prst), .compressed_channel_reset(crst),
        .cfg_addr_load(cl), .cfg_addr(ca), .cfg_addr_check(cc));
    dhi_host_model host (.clk(clk), .q(q), .oe(oe), .sdo(sdo),
        .cs_n(cs_n), .ds_n(ds_n), .rw(rw), .a(a), .d(d), .sclk(sclk),
        .sdi(sdi));
    // clock at 100 ns
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // record every push pulse seen at the input buffers
    always @(posedge clk) begin
        if (reset) begin
            pn <= 4'h0;
            cn <= 4'h0;
        end
        if (pp === 1'h1) begin
            plast <= pb;
            pn <= pn + 4'h1;
        end
        if (cp === 1'h1) begin
            clast <= cb;
            cn <= cn + 4'h1;
        end
    end
    task chk(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task rst;
        reset = 1'h1;
        repeat (8) @(negedge clk);
        reset = 1'h0;
        repeat (3) @(negedge clk);
    endtask
    // one pulse on the dsp side, then let the flags settle
    task dsp(input logic t, p, input logic [7:0] b);
        @(negedge clk);
        {take, put, mb} = {t, p, b};
        @(negedge clk);
        {take, put} = 2'h0;
        repeat (2) @(negedge clk);
    endtask
    // load a new serial address setting between frames
    task cfg(input logic [8:0] v);
        @(negedge clk);
        {cl, ca, cc} = v;
        @(negedge clk);
        cl = 1'h0;
    endtask
    task t_data;
        host.par(1'h0, 2'h2, 8'h5A, rd);
        chk(plast, 8'h5A);
        host.par(1'h0, 2'h3, 8'hC3, rd);
        chk(clast, 8'hC3);
        chk({pn, cn}, 8'h11);
        host.par(1'h1, 2'h3, 8'h00, rd);
        chk(rd, 8'h00);
        chk({7'h0, oe}, 8'h00);
    endtask
    task t_ctrl;
        paf = 1'h1;
        host.par(1'h0, 2'h1, 8'h60, rd);
        chk({6'h0, crst, prst}, 8'h03);
        host.par(1'h1, 2'h1, 8'h00, rd);
        chk(rd & 8'h1E, 8'h10);
        {paf, caf} = 2'h1;
        host.par(1'h0, 2'h1, 8'h00, rd);
        chk({6'h0, crst, prst}, 8'h00);
        host.par(1'h1, 2'h1, 8'h00, rd);
        chk(rd & 8'h1E, 8'h08);
        caf = 1'h0;
    endtask
    task t_msg;
        host.par(1'h0, 2'h0, 8'h96, rd);
        chk(m2d, 8'h96);
        chk({7'h0, busy}, 8'h01);
        dsp(1'h1, 1'h0, 8'h00);
        chk({7'h0, busy}, 8'h00);
        dsp(1'h0, 1'h1, 8'h69);
        chk({7'h0, rdy}, 8'h01);
        host.par(1'h1, 2'h0, 8'h00, rd);
        chk(rd, 8'h69);
        chk({6'h0, rdy, oe}, 8'h00);
    endtask
    task t_spi;
        spi_mode = 1'h1;
        rst;
        host.frame(8'h00, 8'hA5, rd);
        repeat (4) @(negedge clk);
        chk(m2d, 8'hA5);
        host.frame(8'h02, 8'h3C, rd);
        repeat (4) @(negedge clk);
        chk(m2d, 8'hA5);
        cfg(9'h103);
        host.frame(8'h02, 8'h3C, rd);
        repeat (4) @(negedge clk);
        chk(m2d, 8'h3C);
        dsp(1'h0, 1'h1, 8'hB4);
        chk({7'h0, aoe}, 8'h01);
        cfg(9'h102);
        host.frame(8'hFF, 8'h00, rd);
        chk(rd, 8'hB4);
        repeat (4) @(negedge clk);
        chk({5'h0, ao, aoe, rdy}, 8'h00);
    endtask
    task conclude;
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        {spi_mode, take, put, paf, caf, mb, cl, ca, cc} = 22'h1;
        {errors, checks} = 0;
        rst;
        t_data;
        t_ctrl;
        t_msg;
        t_spi;
        conclude;
    end
    // watchdog well past the expected run
    initial begin
        #400000;
        errors++;
        conclude;
    end
endmodule
